//--- verilog/abd_defines.svh
`ifndef ABD_DEFINES_SVH
`define ABD_DEFINES_SVH
// register offsets (8-bit registers on the plain port)
`define ABD_ADDR_W 4
`define ABD_OFS_BAUD_CONTROL 4'h0
`define ABD_OFS_DIV_LOW 4'h1
`define ABD_OFS_DIV_HIGH 4'h2
`define ABD_OFS_TX_STATUS_CONTROL 4'h3
`define ABD_OFS_RX_STATUS_CONTROL 4'h4
`define ABD_OFS_RECEIVE_BUFFER 4'h5
`define ABD_OFS_IRQ_FLAGS 4'h6
`define ABD_OFS_IRQ_ENABLES 4'h7
`define ABD_OFS_IRQ_CLEAR 4'h8
// baud_control fields
`define ABD_BC_START 0
`define ABD_BC_WAKE 1
`define ABD_BC_WIDE 3
`define ABD_BC_RX_IDLE 6
`define ABD_BC_OVF 7
// transmit_status_control field
`define ABD_TX_HIGH_RATE 2
// irq status fields
`define ABD_IRQ_DONE 0
`define ABD_IRQ_OVF 1
`define ABD_IRQ_RECEIVE 5
// receive_status_control reset
`define ABD_RX_RESET 8'h00
// prescale to the measurement clock (oscillator cycles); last rise count and measurement count start
`define ABD_DIV_512 10'h1ff
`define ABD_DIV_128 10'h07f
`define ABD_DIV_32 10'h01f
`define ABD_RISE_LAST 3'h5
`define ABD_COUNT_START 16'h0001
`endif

//--- verilog/abd_pkg.sv
package abd_pkg;
  typedef enum logic [3:0] {
    ABD_IDLE = 4'b0001,
    ABD_WAIT_START = 4'b0010,
    ABD_WAIT_RISE = 4'b0100,
    ABD_MEASURE = 4'b1000
  } abd_state_t;
endpackage

//--- verilog/abd_sync.sv
`timescale 1ns/1ps
module abd_sync (
  input wire logic clk_in, // clock
  input wire logic srst_in, // sync reset, high
  input wire logic async_in, // pin level
  output logic sync_out // synchronised level
);
  typedef struct packed {
    logic stage1;
    logic stage2;
  } abd_sync_st_t;
  abd_sync_st_t r;
  abd_sync_st_t next_r;
  always_comb begin
    next_r.stage1 = async_in;
    next_r.stage2 = r.stage1;
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r <= '{stage1: 1'b1, stage2: 1'b1};
    end else begin
      r <= next_r;
    end
  end
  assign sync_out = r.stage2;
endmodule

//--- verilog/abd_tick.sv
`timescale 1ns/1ps
`include "abd_defines.svh"
module abd_tick (
  input wire logic clk_in, // clock
  input wire logic srst_in, // sync reset, high
  input wire logic run_in, // count while high
  input wire logic wide_in, // wide divisor select
  input wire logic high_in, // high rate select
  output logic tick_out // one-cycle measurement clock
);
  typedef struct packed {
    logic [9:0] cnt;
    logic tick;
  } abd_tick_st_t;
  abd_tick_st_t r;
  abd_tick_st_t next_r;
  logic [9:0] limit;
  always_comb begin
    case ({wide_in, high_in})
      2'b00: limit = `ABD_DIV_512;
      2'b11: limit = `ABD_DIV_32;
      default: limit = `ABD_DIV_128;
    endcase
    next_r = r;
    next_r.tick = 1'b0;
    if (!run_in) begin
      next_r.cnt = 10'h000;
    end else if (r.cnt >= limit) begin
      next_r.cnt = 10'h000;
      next_r.tick = 1'b1;
    end else begin
      next_r.cnt = r.cnt + 10'h001;
    end
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r <= '{cnt: 10'h000, tick: 1'b0};
    end else begin
      r <= next_r;
    end
  end
  assign tick_out = r.tick;
endmodule

//--- verilog/abd_uart_autobaud.sv
`timescale 1ns/1ps
`include "abd_defines.svh"
module abd_uart_autobaud
  import abd_pkg::*;
(
  input wire logic clk_in, // 250 MHz oscillator
  input wire logic srst_in, // sync reset, high
  input wire logic rx_in, // serial input pin
  input wire logic [`ABD_ADDR_W-1:0] addr_in, // register address
  input wire logic [7:0] wdata_in, // write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  output logic [7:0] rdata_out, // read data, cycle after strobe
  output logic irq_out, // level interrupt
  output logic rx_idle_out // receive state machine held idle
);
  typedef struct packed {
    abd_state_t state;
    logic start;
    logic wake;
    logic wide;
    logic high;
    logic ovf;
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] tx_ctl;
    logic [7:0] rx_ctl;
    logic [7:0] rx_buf;
    logic [7:0] irq_stat;
    logic [7:0] irq_en;
    logic [2:0] rises;
    logic brk_seen;
    logic rx_prev;
    logic [7:0] rdata;
    logic irq;
    logic idle;
  } abd_st_t;

  abd_st_t r;
  abd_st_t next_r;
  logic rx_s;
  logic tick;
  logic measuring;
  logic [15:0] cnt_now;
  logic [15:0] cnt_inc;
  logic rise;
  logic fall;

  function automatic logic hit(input logic [`ABD_ADDR_W-1:0] a,
                               input logic [`ABD_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  abd_sync u_sync (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .async_in(rx_in),
    .sync_out(rx_s)
  );

  assign measuring = (r.state == ABD_MEASURE);

  abd_tick u_tick (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .run_in(measuring),
    .wide_in(r.wide),
    .high_in(r.high),
    .tick_out(tick)
  );

  assign cnt_now = {r.div_high, r.div_low};
  assign cnt_inc = cnt_now + 16'h0001;
  assign rise = rx_s & ~r.rx_prev;
  assign fall = ~rx_s & r.rx_prev;

  always_comb begin
    next_r = r;
    next_r.rx_prev = rx_s;
    next_r.rdata = 8'h00;

    // register writes
    if (wr_in) begin
      if (hit(addr_in, `ABD_OFS_BAUD_CONTROL)) begin
        next_r.start = wdata_in[`ABD_BC_START];
        next_r.wake = wdata_in[`ABD_BC_WAKE];
        next_r.wide = wdata_in[`ABD_BC_WIDE];
        if (!wdata_in[`ABD_BC_OVF]) begin
          next_r.ovf = 1'b0;
        end
      end
      if (hit(addr_in, `ABD_OFS_DIV_LOW)) begin
        next_r.div_low = wdata_in;
      end
      if (hit(addr_in, `ABD_OFS_DIV_HIGH)) begin
        next_r.div_high = wdata_in;
      end
      if (hit(addr_in, `ABD_OFS_TX_STATUS_CONTROL)) begin
        next_r.tx_ctl = wdata_in;
        next_r.high = wdata_in[`ABD_TX_HIGH_RATE];
      end
      if (hit(addr_in, `ABD_OFS_RX_STATUS_CONTROL)) begin
        next_r.rx_ctl = wdata_in;
      end
      if (hit(addr_in, `ABD_OFS_IRQ_ENABLES)) begin
        next_r.irq_en = wdata_in;
      end
      if (hit(addr_in, `ABD_OFS_IRQ_CLEAR)) begin
        next_r.irq_stat = r.irq_stat & ~wdata_in;
      end
    end

    // register reads
    if (rd_in) begin
      case (addr_in)
        `ABD_OFS_BAUD_CONTROL: begin
          next_r.rdata[`ABD_BC_START] = r.start;
          next_r.rdata[`ABD_BC_WAKE] = r.wake;
          next_r.rdata[`ABD_BC_WIDE] = r.wide;
          next_r.rdata[`ABD_BC_RX_IDLE] = r.idle;
          next_r.rdata[`ABD_BC_OVF] = r.ovf;
        end
        `ABD_OFS_DIV_LOW: next_r.rdata = r.div_low;
        `ABD_OFS_DIV_HIGH: next_r.rdata = r.div_high;
        `ABD_OFS_TX_STATUS_CONTROL: next_r.rdata = r.tx_ctl;
        `ABD_OFS_RX_STATUS_CONTROL: next_r.rdata = r.rx_ctl;
        `ABD_OFS_RECEIVE_BUFFER: begin
          next_r.rdata = r.rx_buf;
          next_r.irq_stat[`ABD_IRQ_RECEIVE] = 1'b0;
        end
        `ABD_OFS_IRQ_FLAGS: next_r.rdata = r.irq_stat;
        `ABD_OFS_IRQ_ENABLES: next_r.rdata = r.irq_en;
        default: next_r.rdata = 8'h00;
      endcase
    end

    // measurement sequence
    case (r.state)
      ABD_IDLE: begin
        next_r.rises = 3'h0;
        next_r.brk_seen = 1'b0;
        if (r.start) begin
          next_r.state = ABD_WAIT_START;
        end
      end
      ABD_WAIT_START: begin
        if (!r.start) begin
          next_r.state = ABD_IDLE;
        end else if (r.wake && !r.brk_seen) begin
          if (fall) begin
            next_r.brk_seen = 1'b1;
          end
        end else if (r.wake && r.brk_seen && rise) begin
          next_r.wake = 1'b0;
        end else if (!r.wake && fall) begin
          next_r.state = ABD_WAIT_RISE;
        end
      end
      ABD_WAIT_RISE: begin
        if (!r.start) begin
          next_r.state = ABD_IDLE;
        end else if (rise) begin
          {next_r.div_high, next_r.div_low} = `ABD_COUNT_START;
          next_r.rises = 3'h1;
          next_r.state = ABD_MEASURE;
        end
      end
      ABD_MEASURE: begin
        if (!r.start) begin
          next_r.state = ABD_IDLE;
        end else if (rise && r.rises == (`ABD_RISE_LAST - 3'h1)) begin
          next_r.start = 1'b0;
          next_r.irq_stat[`ABD_IRQ_RECEIVE] = 1'b1;
          next_r.irq_stat[`ABD_IRQ_DONE] = 1'b1;
          next_r.state = ABD_IDLE;
        end else begin
          if (rise) begin
            next_r.rises = r.rises + 3'h1;
          end
          if (tick) begin
            {next_r.div_high, next_r.div_low} = cnt_inc;
            if (cnt_now == 16'hffff) begin
              next_r.ovf = 1'b1;
              next_r.irq_stat[`ABD_IRQ_OVF] = 1'b1;
            end
          end
        end
      end
      default: next_r.state = ABD_IDLE;
    endcase

    next_r.idle = (next_r.state != ABD_IDLE) || next_r.start;
    next_r.irq = |(next_r.irq_stat & next_r.irq_en);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r <= '{state: ABD_IDLE, start: 1'b0, wake: 1'b0, wide: 1'b0, high: 1'b0,
             ovf: 1'b0, div_low: 8'h00, div_high: 8'h00, tx_ctl: 8'h00,
             rx_ctl: `ABD_RX_RESET, rx_buf: 8'h00, irq_stat: 8'h00,
             irq_en: 8'h00, rises: 3'h0, brk_seen: 1'b0, rx_prev: 1'b1,
             rdata: 8'h00, irq: 1'b0, idle: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign rdata_out = r.rdata;
  assign irq_out = r.irq;
  assign rx_idle_out = r.idle;
endmodule

//--- verif/abd_props.sv
`timescale 1ns/1ps
`include "abd_defines.svh"
module abd_props (
  input wire logic clk_in, // clock
  input wire logic srst_in, // sync reset
  input wire logic rx_in, // serial line
  input wire logic [`ABD_ADDR_W-1:0] addr_in, // address
  input wire logic [7:0] wdata_in, // write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  input wire logic [7:0] rdata_out, // read data
  input wire logic irq_out, // interrupt
  input wire logic rx_idle_out // receiver held idle
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  AST_RD_ZERO: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside read slot");
  AST_ARM: assert property (wr_in && addr_in == 4'h0 && wdata_in[0] |-> ##[1:2] rx_idle_out)
    else $error("arming did not hold receiver idle");
  AST_ABORT: assert property (wr_in && addr_in == 4'h0 && !wdata_in[0] |-> ##[1:2] !rx_idle_out)
    else $error("clearing start did not stop calibration");
  AST_RBUF: assert property (rd_in && addr_in == 4'h5 |=> rdata_out == 8'h00)
    else $error("receive buffer not zero after calibration");
  AST_UNMAP: assert property (rd_in && addr_in > 4'h8 |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  AST_MASK: assert property (wr_in && addr_in == 4'h7 && wdata_in == 8'h00 |-> ##2 !irq_out)
    else $error("masked interrupt still high");
  AST_IDLE_RISE: assert property ($rose(rx_idle_out) |-> $past(wr_in) || $past(wr_in, 2))
    else $error("receiver idle without a write");
  AST_IRQ_RISE: assert property ($rose(irq_out) && !rx_idle_out |->
    rx_in || $past(wr_in) || $past(wr_in, 2))
    else $error("interrupt rose off a rising edge");
  AST_IDLE_FALL: assert property ($fell(rx_idle_out) |-> rx_in || $past(wr_in, 2))
    else $error("calibration ended with line low");
endmodule
bind abd_uart_autobaud abd_props abd_props_i (.clk_in(clk_in), .srst_in(srst_in), .rx_in(rx_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .irq_out(irq_out), .rx_idle_out(rx_idle_out));

//--- verif/abd_remote_tx.sv
`timescale 1ns/1ps
module abd_remote_tx (
  output logic rx_out // serial line, idle high
);
  initial rx_out = 1'b1;
  // one frame lsb first, then one idle bit
  task automatic send(input int bc, input bit brk);
    logic [9:0] fr;
    fr = brk ? 10'h000 : {1'b1, 8'h55, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_out = fr[i];
      #(bc * 4);
    end
    rx_out = 1'b1;
    #(bc * 4);
  endtask
endmodule

//--- verif/tb_abd_uart_autobaud.sv
`timescale 1ns/1ps
module tb_abd_uart_autobaud;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic rx_in;
  logic [7:0] rdata_out;
  logic irq_out;
  logic rx_idle_out;
  logic [31:0] seed = 32'hb66f2f94;
  logic [7:0] d;
  int err_count = 0;
  int checks = 0;
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  abd_remote_tx abd_remote_tx_i (.rx_out(rx_in));
  abd_uart_autobaud abd_uart_autobaud_i (.clk_in(clk_in), .srst_in(srst_in), .rx_in(rx_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .irq_out(irq_out), .rx_idle_out(rx_idle_out));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int per(input logic w, input logic h);
    return (w & h) ? 32 : ((w | h) ? 128 : 512);
  endfunction
  function automatic int exp_cnt(input int bc, input int p);
    return 1 + 8 * bc / p;
  endfunction
  task automatic finish_test;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic chkc(input string n, input int e, input logic [15:0] s);
    checks++;
    if ($isunknown(s) || s + 1 < e || s > e + 1) begin
      err_count++;
      $display("CHECK FAILED %s exp %0d got %0d", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic cal(input logic w, input logic h, input int k, input bit b, input logic [7:0] en);
    int p;
    int bc;
    int i;
    logic [7:0] lo;
    p = per(w, h);
    bc = k * p / 8;
    wr(4'h7, en);
    wr(4'h3, {5'h00, h, 2'h0});
    wr(4'h0, {4'h0, w, 1'b0, b, 1'b1});
    repeat (2) @(posedge clk_in);
    #1 chk8("idle", 8'h01, {7'h00, rx_idle_out});
    if (b) begin
      abd_remote_tx_i.send(bc, 1'b1);
      chk8("idle", 8'h01, {7'h00, rx_idle_out});
    end
    abd_remote_tx_i.send(bc, 1'b0);
    for (i = 0; i < 100 && rx_idle_out !== 1'b0; i++) @(posedge clk_in);
    if (i == 100) begin
      err_count++;
      finish_test();
    end
    chk8("irq", {7'h00, |en}, {7'h00, irq_out});
    rd(4'h1);
    lo = d;
    rd(4'h2);
    chkc("count", exp_cnt(bc, p), {d, lo});
    if (k < 250) chk8("high", 8'h00, d);
    rd(4'h0);
    chk8("ctrl", {4'h0, w, 3'h0}, d);
    rd(4'h6);
    chk8("flags", 8'h21, d);
    rd(4'h5);
    chk8("rbuf", 8'h00, d);
    rd(4'h6);
    chk8("flags", 8'h01, d);
    wr(4'h8, 8'h01);
    repeat (2) @(posedge clk_in);
    #1 chk8("irq", 8'h00, {7'h00, irq_out});
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(4'h0);
    chk8("ctrl", 8'h00, d);
    rd(4'hf);
    chk8("unmapped", 8'h00, d);
    wr(4'h4, seed[7:0]);
    rd(4'h4);
    chk8("rxctl", seed[7:0], d);
    for (int m = 0; m < 4; m++) begin
      seed = lfsr(seed);
      cal(m[1], m[0], 4 + seed[3:0], 1'b0, m[0] ? 8'h21 : 8'h00);
    end
    cal(1'b1, 1'b1, 300, 1'b0, 8'h21);
    cal(1'b0, 1'b1, 6, 1'b1, 8'h21);
    wr(4'h0, 8'h01);
    wr(4'h0, 8'h00);
    repeat (2) @(posedge clk_in);
    #1 chk8("abort", 8'h00, {7'h00, rx_idle_out});
    finish_test();
  end
endmodule
